// ==== hdl/ub_pkg.sv ====
// constants for the utility unit register bank
package ub_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int THRESH_W = 20;
	localparam int NODE_W = 3;
	localparam int GROUPS = 8;
	localparam int FLAGS = 8;

	localparam logic [7:0] OFF_NODE_MAP = 8'h54;
	localparam logic [7:0] OFF_ERR_STATUS = 8'h64;
	localparam logic [7:0] OFF_BUS_NUMBER = 8'hd0;
	localparam logic [7:0] OFF_IRQ_CTRL = 8'hd8;

	// error status fields
	localparam int ST_DELIVERY_VALID = 16;
	localparam int ST_LOCK_TIMEOUT = 7;
	localparam int ST_MGMT_TIMEOUT = 6;
	localparam int ST_CFG_WR_MISALIGN = 5;
	localparam int ST_CFG_RD_MISALIGN = 4;
	localparam int ST_BAD_OPCODE = 3;
	localparam int ST_POISONED = 2;
	localparam int ST_SRC_MEM_CTRL = 1;
	localparam int ST_SRC_MACHINE_CHECK = 0;

	// bus number fields
	localparam int BUS_VALID = 31;
	localparam int BUS_UNCORE_LSB = 8;
	localparam int BUS_IIO_LSB = 0;

	// control fields
	localparam int CTL_CORE_MSG_DIS = 28;
	localparam int CTL_MSG_CHAN_DIS = 27;
	localparam int CTL_LOCK_MISALIGN_DIS = 26;
	localparam int CTL_ALL_DIS = 25;
	localparam int CTL_MC_IRQ_EN = 24;
	localparam int CTL_THRESH_LSB = 0;

	localparam logic [23:0] NODE_MAP_RESET = 24'h000000;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [31:0] BUS_NUMBER_RESET = 32'h00000000;
	localparam logic [4:0] CTL_BITS_RESET = 5'h04;
	localparam logic [19:0] THRESH_RESET = 20'h00000;
endpackage

// ==== hdl/ub_countdown.sv ====
// threshold countdown before a machine-check management interrupt
`timescale 1ns/1ps
module ub_countdown import ub_pkg::*; #(
	parameter int WIDTH = THRESH_W
) (
	input wire logic clk, // core clock
	input wire logic reset, // synchronous, active high
	input wire logic start, // load and begin counting
	input wire logic abort, // drop a running count
	input wire logic [WIDTH-1:0] loadValue, // threshold to count down
	output logic expired, // one-cycle pulse at zero
	output logic busy // a count is running
);
	logic [WIDTH-1:0] count;

	if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
		$error("ub_countdown: WIDTH out of range");
	end

	assign expired = busy && count == '0;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (reset || abort) begin
			busy <= 1'b0;
		end else if (start) begin
			busy <= 1'b1;
		end else if (expired) begin
			busy <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count <= '0;
		end else if (start) begin
			count <= loadValue;
		end else if (busy && count != '0) begin
			count <= count - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_count_down: assert property (@(posedge clk) disable iff (reset)
		busy && !start && !abort && count != '0 |=>
		count == $past(count) - 1'b1)
		else $error("countdown did not decrement");
endmodule

// ==== hdl/ub_regs.sv ====
// utility unit configuration registers and management interrupt logic
`timescale 1ns/1ps
// Summary of operation
// - eight 3-bit node fields, group 7 highest, group 0 lowest, reset zero
// - delivery-valid at status bit 16, cleared by software writing one
// - status bit 7 sticky on lock timeout, survives warm reset
// - status bit 6 sticky on management interrupt timeout
// - bit 5 on misaligned config write, bit 4 on misaligned read
// - bit 3 sticky on unsupported opcode
// - bit 2 sticky on poisoned transaction
// - bit 1 set when interrupt raised from memory controller
// - bit 0 set when interrupt raised from local machine check
// - bus register bit 31 marks bus numbers initialised, reset zero
// - bits 15:8 uncore bus number, bits 7:0 integrated I/O bus number
// - control bit 25 blocks every management interrupt
// - bit 26 blocks lock timeout and misalign interrupts, resets one
// - bit 27 blocks interrupts from the message channel
// - bit 28 blocks interrupts from core messages on message channel
// - bit 24 enables machine-check interrupt after threshold expiry
// - threshold in bits 19:0 counted down in hardware, reset zero
module ub_regs import ub_pkg::*; (
	input wire logic clk, // core clock
	input wire logic reset, // synchronous cold reset
	input wire logic warmReset, // synchronous warm reset
	input wire logic cfgWrEn, // config write strobe
	input wire logic cfgRdEn, // config read strobe
	input wire logic [ADDR_W-1:0] cfgAddr, // config byte offset
	input wire logic [3:0] cfgByteEn, // write byte lanes
	input wire logic [DATA_W-1:0] cfgWrData, // write data
	output logic [DATA_W-1:0] cfgRdData, // read data
	output logic cfgRdValid, // read data strobe
	input wire logic lockTimeoutEvt, // lock master timeout seen
	input wire logic mgmtTimeoutEvt, // interrupt timeout seen
	input wire logic cfgWrMisalignEvt, // misaligned config write
	input wire logic cfgRdMisalignEvt, // misaligned config read
	input wire logic badOpcodeEvt, // unsupported opcode seen
	input wire logic poisonedEvt, // poisoned transaction seen
	input wire logic memCtrlEvt, // memory controller indication
	input wire logic machineCheckEvt, // local uncorrectable check
	input wire logic msgChannelEvt, // request from message channel
	input wire logic coreMsgEvt, // core message on message channel
	input wire logic [2:0] groupSelect, // group to look up
	output logic [NODE_W-1:0] selectedNode, // node of that group
	output logic [7:0] uncoreBusNumber, // non-I/O uncore bus
	output logic [7:0] integratedIoBusNumber, // integrated I/O bus
	output logic busNumbersValid, // bus numbers initialised
	output logic managementInterrupt // one-cycle interrupt pulse
);
	logic [GROUPS*NODE_W-1:0] nodeMap;
	logic [FLAGS-1:0] errFlags;
	logic [FLAGS-1:0] flagSet;
	logic [FLAGS-1:0] flagClear;
	logic deliveryValid;
	logic busValid;
	logic [7:0] uncoreBus;
	logic [7:0] iioBus;
	logic coreMsgDis;
	logic msgChanDis;
	logic lockMisalignDis;
	logic allDis;
	logic mcIrqEn;
	logic [THRESH_W-1:0] threshold;
	logic wrMap;
	logic wrStatus;
	logic wrBus;
	logic wrCtrl;
	logic [DATA_W-1:0] busWord;
	logic [DATA_W-1:0] ctrlWord;
	logic [DATA_W-1:0] statusWord;
	logic [DATA_W-1:0] next_bus;
	logic [DATA_W-1:0] next_ctrl;
	logic [DATA_W-1:0] next_map;
	logic reqLock;
	logic reqMemCtrl;
	logic reqMsg;
	logic reqCore;
	logic gateLock;
	logic gateMemCtrl;
	logic gateMsg;
	logic gateCore;
	logic gateMc;
	logic mcExpired;
	logic deliverNow;

	////////////////////////////////////////////////////////////////////////
	// decode and byte-lane merge helpers
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] off);
		hit = a[7:2] == off[7:2];
	endfunction

	function automatic logic [DATA_W-1:0] merge(
		input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] wr,
		input logic [3:0] be);
		logic [DATA_W-1:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wr[i*8 +: 8];
			end
		end
		merge = res;
	endfunction

	assign wrMap = cfgWrEn && hit(cfgAddr, OFF_NODE_MAP);
	assign wrStatus = cfgWrEn && hit(cfgAddr, OFF_ERR_STATUS);
	assign wrBus = cfgWrEn && hit(cfgAddr, OFF_BUS_NUMBER);
	assign wrCtrl = cfgWrEn && hit(cfgAddr, OFF_IRQ_CTRL);

	assign busWord = {busValid, 15'h0000, uncoreBus, iioBus};
	assign ctrlWord = {3'h0, coreMsgDis, msgChanDis, lockMisalignDis,
		allDis, mcIrqEn, 4'h0, threshold};
	assign statusWord = {15'h0000, deliveryValid, 8'h00, errFlags};
	assign next_map = merge({8'h00, nodeMap}, cfgWrData, cfgByteEn);
	assign next_bus = merge(busWord, cfgWrData, cfgByteEn);
	assign next_ctrl = merge(ctrlWord, cfgWrData, cfgByteEn);

	////////////////////////////////////////////////////////////////////////
	// group to node map
	always_ff @(posedge clk) begin
		if (reset) begin
			nodeMap <= NODE_MAP_RESET;
		end else if (wrMap) begin
			nodeMap <= next_map[GROUPS*NODE_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			selectedNode <= '0;
		end else begin
			selectedNode <= nodeMap[groupSelect*NODE_W +: NODE_W];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus numbers
	always_ff @(posedge clk) begin
		if (reset) begin
			busValid <= BUS_NUMBER_RESET[BUS_VALID];
			uncoreBus <= BUS_NUMBER_RESET[BUS_UNCORE_LSB +: 8];
			iioBus <= BUS_NUMBER_RESET[BUS_IIO_LSB +: 8];
		end else if (wrBus) begin
			busValid <= next_bus[BUS_VALID];
			uncoreBus <= next_bus[BUS_UNCORE_LSB +: 8];
			iioBus <= next_bus[BUS_IIO_LSB +: 8];
		end
	end

	assign uncoreBusNumber = uncoreBus;
	assign integratedIoBusNumber = iioBus;
	assign busNumbersValid = busValid;

	////////////////////////////////////////////////////////////////////////
	// interrupt control
	always_ff @(posedge clk) begin
		if (reset) begin
			{coreMsgDis, msgChanDis, lockMisalignDis, allDis, mcIrqEn}
				<= CTL_BITS_RESET;
			threshold <= THRESH_RESET;
		end else if (wrCtrl) begin
			coreMsgDis <= next_ctrl[CTL_CORE_MSG_DIS];
			msgChanDis <= next_ctrl[CTL_MSG_CHAN_DIS];
			lockMisalignDis <= next_ctrl[CTL_LOCK_MISALIGN_DIS];
			allDis <= next_ctrl[CTL_ALL_DIS];
			mcIrqEn <= next_ctrl[CTL_MC_IRQ_EN];
			threshold <= next_ctrl[CTL_THRESH_LSB +: THRESH_W];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt sources and gating
	assign reqLock = lockTimeoutEvt || cfgWrMisalignEvt || cfgRdMisalignEvt;
	assign reqMemCtrl = memCtrlEvt;
	assign reqMsg = msgChannelEvt;
	assign reqCore = coreMsgEvt;
	assign gateLock = reqLock && !lockMisalignDis;
	assign gateMemCtrl = reqMemCtrl;
	assign gateMsg = reqMsg && !msgChanDis;
	assign gateCore = reqCore && !coreMsgDis && !msgChanDis;
	assign gateMc = mcExpired && mcIrqEn;
	assign deliverNow = !allDis && (gateLock || gateMemCtrl || gateMsg
		|| gateCore || gateMc);

	ub_countdown #(
		.WIDTH(THRESH_W)
	) u_countdown (
		.clk(clk),
		.reset(reset || warmReset),
		.start(machineCheckEvt && mcIrqEn),
		.abort(!mcIrqEn),
		.loadValue(threshold),
		.expired(mcExpired),
		.busy()
	);

	always_ff @(posedge clk) begin
		if (reset || warmReset) begin
			managementInterrupt <= 1'b0;
		end else begin
			managementInterrupt <= deliverNow;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky status flags; set wins over a write-one clear
	assign flagSet[ST_LOCK_TIMEOUT] = lockTimeoutEvt;
	assign flagSet[ST_MGMT_TIMEOUT] = mgmtTimeoutEvt;
	assign flagSet[ST_CFG_WR_MISALIGN] = cfgWrMisalignEvt;
	assign flagSet[ST_CFG_RD_MISALIGN] = cfgRdMisalignEvt;
	assign flagSet[ST_BAD_OPCODE] = badOpcodeEvt;
	assign flagSet[ST_POISONED] = poisonedEvt;
	assign flagSet[ST_SRC_MEM_CTRL] = deliverNow && gateMemCtrl;
	assign flagSet[ST_SRC_MACHINE_CHECK] = deliverNow && gateMc;
	assign flagClear = (wrStatus && cfgByteEn[0]) ? cfgWrData[7:0] : 8'h00;

	// warm reset leaves these alone
	generate
		for (genvar i = 0; i < FLAGS; i++) begin : g_flag
			always_ff @(posedge clk) begin
				if (reset) begin
					errFlags[i] <= FLAGS_RESET[i];
				end else if (flagSet[i]) begin
					errFlags[i] <= 1'b1;
				end else if (flagClear[i]) begin
					errFlags[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (reset || warmReset) begin
			deliveryValid <= 1'b0;
		end else if (deliverNow) begin
			deliveryValid <= 1'b1;
		end else if (wrStatus && cfgByteEn[2]
			&& cfgWrData[ST_DELIVERY_VALID]) begin
			deliveryValid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port
	always_ff @(posedge clk) begin
		if (reset) begin
			cfgRdData <= '0;
			cfgRdValid <= 1'b0;
		end else begin
			cfgRdValid <= cfgRdEn;
			if (cfgRdEn) begin
				if (hit(cfgAddr, OFF_NODE_MAP)) begin
					cfgRdData <= {8'h00, nodeMap};
				end else if (hit(cfgAddr, OFF_ERR_STATUS)) begin
					cfgRdData <= statusWord;
				end else if (hit(cfgAddr, OFF_BUS_NUMBER)) begin
					cfgRdData <= busWord;
				end else if (hit(cfgAddr, OFF_IRQ_CTRL)) begin
					cfgRdData <= ctrlWord;
				end else begin
					cfgRdData <= '0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	chk_map_write: assert property (@(posedge clk) disable iff (reset)
		wrMap && cfgByteEn == 4'hf |=>
		nodeMap == $past(cfgWrData[23:0]))
		else $error("node map write lost");

	chk_valid_clear: assert property (@(posedge clk)
		disable iff (reset || warmReset)
		wrStatus && cfgByteEn[2] && cfgWrData[ST_DELIVERY_VALID]
		&& !deliverNow |=> !deliveryValid)
		else $error("delivery valid not cleared");

	chk_lock_flag: assert property (@(posedge clk) disable iff (reset)
		lockTimeoutEvt |=> errFlags[ST_LOCK_TIMEOUT])
		else $error("lock timeout flag missing");

	// sticky flag must ride through a warm reset
	chk_lock_warm: assert property (@(posedge clk) disable iff (reset)
		warmReset && errFlags[ST_LOCK_TIMEOUT]
		&& !flagClear[ST_LOCK_TIMEOUT]
		|=> errFlags[ST_LOCK_TIMEOUT])
		else $error("lock flag lost on warm reset");

	chk_timeout_flag: assert property (@(posedge clk) disable iff (reset)
		mgmtTimeoutEvt |=> errFlags[ST_MGMT_TIMEOUT])
		else $error("interrupt timeout flag missing");

	chk_misalign_flags: assert property (@(posedge clk) disable iff (reset)
		cfgWrMisalignEvt || cfgRdMisalignEvt |=>
		(errFlags[ST_CFG_WR_MISALIGN] || !$past(cfgWrMisalignEvt)) &&
		(errFlags[ST_CFG_RD_MISALIGN] || !$past(cfgRdMisalignEvt)))
		else $error("misalign flag missing");

	chk_opcode_flag: assert property (@(posedge clk) disable iff (reset)
		badOpcodeEvt |=> errFlags[ST_BAD_OPCODE])
		else $error("opcode flag missing");

	chk_poison_flag: assert property (@(posedge clk) disable iff (reset)
		poisonedEvt |=> errFlags[ST_POISONED])
		else $error("poison flag missing");

	chk_memctrl_source: assert property (@(posedge clk)
		disable iff (reset || warmReset)
		memCtrlEvt && !allDis |=> managementInterrupt
		&& errFlags[ST_SRC_MEM_CTRL])
		else $error("memory controller source missing");

	chk_all_disable: assert property (@(posedge clk)
		disable iff (reset || warmReset)
		allDis |=> !managementInterrupt)
		else $error("interrupt despite global disable");

	chk_lock_gate: assert property (@(posedge clk) disable iff (reset)
		lockMisalignDis && !reqMemCtrl && !reqMsg && !reqCore
		&& !mcExpired |=> !managementInterrupt)
		else $error("blocked lock interrupt delivered");

	chk_msg_gate: assert property (@(posedge clk) disable iff (reset)
		msgChanDis && !reqLock && !reqMemCtrl && !mcExpired
		|=> !managementInterrupt)
		else $error("blocked channel interrupt delivered");

	chk_mc_threshold: assert property (@(posedge clk)
		disable iff (reset || warmReset)
		machineCheckEvt && mcIrqEn && !allDis && threshold == 20'h00002
		##1 (mcIrqEn && !allDis && !machineCheckEvt && !wrCtrl) [*3]
		|=> managementInterrupt && errFlags[ST_SRC_MACHINE_CHECK])
		else $error("machine check interrupt timing wrong");

	chk_delivery_pair: assert property (@(posedge clk)
		disable iff (reset || warmReset)
		managementInterrupt |-> deliveryValid)
		else $error("delivery without valid status");

	cov_mc_irq: cover property (@(posedge clk) disable iff (reset)
		gateMc && deliverNow ##1 managementInterrupt);
	cov_w1c: cover property (@(posedge clk) disable iff (reset)
		deliveryValid ##1 !deliveryValid);
	cov_status_read: cover property (@(posedge clk) disable iff (reset)
		cfgRdEn && hit(cfgAddr, OFF_ERR_STATUS) ##1 cfgRdData != '0);
endmodule

// ==== test/tb_top.sv ====
// self-checking testbench for the utility unit register bank
`timescale 1ns/1ps
module tb_top import ub_pkg::*;;
	logic clk = 1'b0;
	logic reset, warmReset, cfgWrEn, cfgRdEn;
	logic [ADDR_W-1:0] cfgAddr;
	logic [3:0] cfgByteEn;
	logic [DATA_W-1:0] cfgWrData, cfgRdData;
	logic cfgRdValid, busNumbersValid, managementInterrupt;
	logic [9:0] evts;
	logic [2:0] groupSelect;
	logic [NODE_W-1:0] selectedNode;
	logic [7:0] uncoreBusNumber, integratedIoBusNumber;
	logic [31:0] miscompares, totalChecks, irqCount, cyc, irqCyc, srcCyc;
	logic [31:0] expQ[$];
	logic [31:0] nodeMap, busVal, thr, n0;
	int i, g;

	ub_regs dut (
		.clk(clk), .reset(reset), .warmReset(warmReset),
		.cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr),
		.cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
		.cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
		.lockTimeoutEvt(evts[0]), .mgmtTimeoutEvt(evts[1]),
		.cfgWrMisalignEvt(evts[2]), .cfgRdMisalignEvt(evts[3]),
		.badOpcodeEvt(evts[4]), .poisonedEvt(evts[5]),
		.memCtrlEvt(evts[6]), .machineCheckEvt(evts[7]),
		.msgChannelEvt(evts[8]), .coreMsgEvt(evts[9]),
		.groupSelect(groupSelect), .selectedNode(selectedNode),
		.uncoreBusNumber(uncoreBusNumber),
		.integratedIoBusNumber(integratedIoBusNumber),
		.busNumbersValid(busNumbersValid),
		.managementInterrupt(managementInterrupt)
	);

	initial begin
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic idle(input int c);
		repeat (c) @(negedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		cfgWrEn = 1'b1;
		cfgAddr = a;
		cfgWrData = d;
		cfgByteEn = be;
		@(negedge clk);
		cfgWrEn = 1'b0;
		// idle cycle keeps back-to-back strobes apart
		@(negedge clk);
	endtask

	// expected word noted here, compared by the monitor
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		cfgRdEn = 1'b1;
		cfgAddr = a;
		expQ.push_back(exp);
		@(negedge clk);
		cfgRdEn = 1'b0;
		@(negedge clk);
	endtask

	task automatic evt(input int k);
		evts[k] = 1'b1;
		@(negedge clk);
		evts = '0;
	endtask

	// one event, then the number of interrupts that followed it
	task automatic src(input int k, input int w, input logic [31:0] expN);
		logic [31:0] n;
		n = irqCount;
		evt(k);
		idle(w);
		chk(irqCount - n, expN);
	endtask

	task automatic test_done(input string name);
		$display("test %s done", name);
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (managementInterrupt === 1'b1) begin
			irqCount <= irqCount + 1;
			irqCyc <= cyc;
		end
		if (evts[6] || evts[7])
			srcCyc <= cyc;
		if (cfgRdValid === 1'b1) begin
			if (expQ.size() == 0)
				chk(cfgRdData, 32'hdeadbeef);
			else
				chk(cfgRdData, expQ.pop_front());
		end
	end

	initial begin
		#20000;
		miscompares++;
		print_verdict();
	end

	initial begin
		{reset, warmReset, cfgWrEn, cfgRdEn} = 4'hf - 4'h7;
		{cfgAddr, cfgByteEn, cfgWrData, evts, groupSelect} = '0;
		{miscompares, totalChecks, irqCount, cyc, irqCyc, srcCyc} = '0;
		idle(8);
		reset = 1'b0;
		void'($urandom(32'h9f1d2eba));
		rd(OFF_NODE_MAP, 32'h0);
		rd(OFF_ERR_STATUS, 32'h0);
		rd(OFF_BUS_NUMBER, 32'h0);
		rd(OFF_IRQ_CTRL, 32'h04000000);
		rd(8'h58, 32'h0);
		test_done("reset values");
		nodeMap = $urandom() & 32'h00ffffff;
		wr(OFF_NODE_MAP, nodeMap, 4'hf);
		rd(OFF_NODE_MAP, nodeMap);
		for (g = 0; g < GROUPS; g++) begin
			groupSelect = g[2:0];
			@(negedge clk);
			chk({29'h0, selectedNode}, {29'h0, nodeMap[3*g+:3]});
		end
		wr(8'h58, 32'hffffffff, 4'hf);
		rd(8'h58, 32'h0);
		test_done("node map");
		busVal = {1'b1, 15'h0, 16'($urandom())};
		wr(OFF_BUS_NUMBER, busVal, 4'hf);
		chk({15'h0, busNumbersValid, uncoreBusNumber, integratedIoBusNumber},
			{15'h0, busVal[31], busVal[15:0]});
		wr(OFF_BUS_NUMBER, 32'h000000ff, 4'h1);
		rd(OFF_BUS_NUMBER, {busVal[31:8], 8'hff});
		test_done("bus numbers");
		for (i = 0; i < 6; i++) begin
			src(i, 2, 32'h0);
			rd(OFF_ERR_STATUS, 32'h1 << (7 - i));
			wr(OFF_ERR_STATUS, 32'h000000ff, 4'h1);
			rd(OFF_ERR_STATUS, 32'h0);
		end
		test_done("error flags");
		src(6, 3, 32'h1);
		chk(irqCyc - srcCyc, 32'h1);
		rd(OFF_ERR_STATUS, 32'h00010002);
		wr(OFF_ERR_STATUS, 32'h00010003, 4'h5);
		rd(OFF_ERR_STATUS, 32'h0);
		wr(OFF_IRQ_CTRL, 32'h03000005, 4'hf);
		for (i = 6; i < 10; i++)
			src(i, 10, 32'h0);
		rd(OFF_ERR_STATUS, 32'h0);
		test_done("all disable");
		wr(OFF_IRQ_CTRL, 32'h0, 4'hf);
		for (i = 0; i < 4; i++)
			src(i, 3, (i == 1) ? 32'h0 : 32'h1);
		src(8, 3, 32'h1);
		src(9, 3, 32'h1);
		wr(OFF_IRQ_CTRL, 32'h04000000, 4'hf);
		for (i = 0; i < 4; i++)
			src(i, 3, 32'h0);
		wr(OFF_IRQ_CTRL, 32'h08000000, 4'hf);
		src(8, 3, 32'h0);
		wr(OFF_IRQ_CTRL, 32'h10000000, 4'hf);
		src(9, 3, 32'h0);
		src(8, 3, 32'h1);
		wr(OFF_ERR_STATUS, 32'h000100ff, 4'h5);
		test_done("source disables");
		thr = 32'd4 + ($urandom() % 6);
		wr(OFF_IRQ_CTRL, 32'h01000000 | thr, 4'hf);
		src(7, thr + 6, 32'h1);
		chk(irqCyc - srcCyc, thr + 2);
		rd(OFF_ERR_STATUS, 32'h00010001);
		wr(OFF_IRQ_CTRL, 32'h01000002, 4'hf);
		src(7, 8, 32'h1);
		chk(irqCyc - srcCyc, 32'h4);
		wr(OFF_IRQ_CTRL, 32'h01000000 | thr, 4'hf);
		n0 = irqCount;
		evt(7);
		idle(2);
		src(7, thr + 6, 32'h1);
		chk(irqCyc - srcCyc, thr + 2);
		evt(7);
		wr(OFF_IRQ_CTRL, thr, 4'hf);
		idle(thr + 4);
		chk(irqCount - n0, 32'h1);
		src(7, thr + 6, 32'h0);
		test_done("machine check");
		wr(OFF_ERR_STATUS, 32'h000100ff, 4'h5);
		wr(OFF_IRQ_CTRL, 32'h04000000, 4'hf);
		evt(0);
		warmReset = 1'b1;
		@(negedge clk);
		warmReset = 1'b0;
		rd(OFF_ERR_STATUS, 32'h00000080);
		rd(OFF_NODE_MAP, nodeMap);
		idle(3);
		chk(expQ.size(), 32'h0);
		test_done("warm reset");
		print_verdict();
	end
endmodule
